// ==== core/rcnc_pkg.sv ====
// How it works
// - Noise suppression off lets noise through
// - Select pin low keeps receiving mode
// - OFF with select low enters start-up
// - Select low skips sleep, bit check runs
// - OFF starts bit check despite select low
// - Successful bit check returns to receiving
// - Two volatile 12-bit registers, serially written
// - Power loss shows marker; host reprograms
// - Reset loads defaults into both registers
// - Frame bit 1 set means OFF
// - Bit 2 selects operating or limits register
// - Stop bit 15 set discards a register write, not OFF
// - Operating register fields and default 000100011001
// - Limits fields, defaults 010101 and 101001
// - Baud band selects limit scale 8/4/2/1
// - Check count field gives 0/3/6/9 bits
// - Modulation bit: 0 FSK, 1 ASK
// - Sleep is value times extension times 1024; value 31 holds until select low
// - Suppression on: bit check, data held high
`default_nettype none

package rcnc_pkg;

   localparam logic [3:0]  FRAME_LAST        = 4'he;
   localparam logic [11:0] OPCFG_RESET       = 12'h119;
   localparam logic [11:0] LIMITS_RESET      = 12'h569;

   localparam int          FR_OFF            = 14;
   localparam int          FR_SEL            = 13;
   localparam int          FR_STOP           = 0;

   localparam int          OP_BAUD_HI        = 11;
   localparam int          OP_BAUD_LO        = 10;
   localparam int          OP_CHK_HI         = 9;
   localparam int          OP_CHK_LO         = 8;
   localparam int          OP_MOD            = 7;
   localparam int          OP_SLEEP_HI       = 6;
   localparam int          OP_SLEEP_LO       = 2;
   localparam int          OP_EXT            = 1;
   localparam int          OP_NOISE          = 0;
   localparam int          LIM_MIN_HI        = 11;
   localparam int          LIM_MIN_LO        = 6;
   localparam int          LIM_MAX_HI        = 5;
   localparam int          LIM_MAX_LO        = 0;

   localparam logic [4:0]  SLEEP_PERMANENT   = 5'h1f;
   localparam logic [23:0] SLEEP_EXT_FACTOR  = 24'h000008;
   localparam int          SLEEP_UNIT_CYCLES = 1024;
   localparam int          MARK_HALF_CYCLES  = 8192;

   typedef enum logic [1:0] {
      RCNC_SLEEP = 2'b00,
      RCNC_CHECK = 2'b01,
      RCNC_RECV  = 2'b11
   } rcnc_mode_t;

   typedef struct packed {
      rcnc_mode_t  mode;
      logic [11:0] opcfg;
      logic [11:0] limits;
      logic [14:0] shift;
      logic [3:0]  nbits;
      logic        framing;
      logic [23:0] sleep_cnt;
      logic        poll_prev;
      logic        marker;
      logic [15:0] mark_cnt;
      logic        mark_phase;
      logic        data_out;
      logic        data_oe;
      logic [3:0]  scale;
      logic [3:0]  check_n;
   } rcnc_state_t;

   function automatic logic [3:0] rcnc_scale_of(input logic [1:0] band);
      case (band)
         2'b00:   rcnc_scale_of = 4'h8;
         2'b01:   rcnc_scale_of = 4'h4;
         2'b10:   rcnc_scale_of = 4'h2;
         default: rcnc_scale_of = 4'h1;
      endcase
   endfunction

   function automatic logic [3:0] rcnc_count_of(input logic [1:0] chk);
      case (chk)
         2'b00:   rcnc_count_of = 4'h0;
         2'b01:   rcnc_count_of = 4'h3;
         2'b10:   rcnc_count_of = 4'h6;
         default: rcnc_count_of = 4'h9;
      endcase
   endfunction

endpackage

`default_nettype wire

// ==== core/rcnc_receiver_config.sv ====
`default_nettype none

module rcnc_receiver_config #(
   parameter int SLEEP_UNIT = rcnc_pkg::SLEEP_UNIT_CYCLES,
   parameter int MARK_HALF  = rcnc_pkg::MARK_HALF_CYCLES
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_rst,
   input  wire logic             i_data_in,
   output var  logic             o_data_out,
   output var  logic             o_data_oe,
   input  wire logic             i_frame_start,
   input  wire logic             i_slot,
   input  wire logic             i_polling_sel,
   input  wire logic             i_demod_data,
   input  wire logic             i_stream_end,
   input  wire logic             i_check_ok,
   input  wire logic             i_check_fail,
   output var  rcnc_pkg::rcnc_mode_t o_mode,
   output var  logic [1:0]       o_baud_band_select,
   output var  logic [3:0]       o_limit_scale_factor,
   output var  logic [3:0]       o_edge_check_count,
   output var  logic             o_modulation_select,
   output var  logic [4:0]       o_sleep_value,
   output var  logic             o_sleep_extend_select,
   output var  logic             o_noise_suppress_en,
   output var  logic [5:0]       o_lim_min,
   output var  logic [5:0]       o_lim_max,
   output var  logic             o_power_loss_marker
);
   import rcnc_pkg::*;

   rcnc_state_t r;
   rcnc_state_t n;
   logic [14:0] fr;
   logic [11:0] fr_cfg;
   logic        frame_done;
   logic        off_cmd;
   logic        poll_rise;

   // Sleep length in clock periods
   function automatic logic [23:0] sleep_load(input logic [11:0] cfg);
      logic [23:0] ext;
      ext = cfg[OP_EXT] ? SLEEP_EXT_FACTOR : 24'h000001;
      sleep_load = 24'(cfg[OP_SLEEP_HI:OP_SLEEP_LO]) * ext * 24'(SLEEP_UNIT);
   endfunction

   assign fr        = {r.shift[13:0], i_data_in};
   assign fr_cfg    = fr[12:1];
   assign poll_rise = i_polling_sel && !r.poll_prev;

   always_comb begin
      n          = r;
      frame_done = 1'b0;
      off_cmd    = 1'b0;
      n.poll_prev = i_polling_sel;

      // Frame capture, first bit lands at the top
      if (i_frame_start) begin
         n.framing = 1'b1;
         n.nbits   = 4'h0;
         n.marker  = 1'b0;
      end else if (r.framing && i_slot) begin
         n.shift = fr;
         n.nbits = r.nbits + 4'h1;
         if (r.nbits == FRAME_LAST) begin
            n.framing  = 1'b0;
            frame_done = 1'b1;
         end
      end

      // Decode
      if (frame_done) begin
         if (fr[FR_OFF]) begin
            off_cmd = 1'b1;
         end else if (!fr[FR_STOP]) begin
            if (fr[FR_SEL]) begin
               n.opcfg = fr_cfg;
            end else begin
               n.limits = fr_cfg;
            end
         end
      end
      n.scale   = rcnc_scale_of(n.opcfg[OP_BAUD_HI:OP_BAUD_LO]);
      n.check_n = rcnc_count_of(n.opcfg[OP_CHK_HI:OP_CHK_LO]);

      // Mode sequencing
      case (r.mode)
         RCNC_SLEEP: begin
            if (!i_polling_sel) begin
               n.mode = RCNC_CHECK;
            end else if (r.opcfg[OP_SLEEP_HI:OP_SLEEP_LO] != SLEEP_PERMANENT) begin
               if (r.sleep_cnt <= 24'h000001) begin
                  n.mode = RCNC_CHECK;
               end else begin
                  n.sleep_cnt = r.sleep_cnt - 24'h000001;
               end
            end
         end
         RCNC_CHECK: begin
            if (r.check_n == 4'h0 || i_check_ok) begin
               n.mode = RCNC_RECV;
            end else if (i_check_fail && i_polling_sel) begin
               n.mode      = RCNC_SLEEP;
               n.sleep_cnt = sleep_load(r.opcfg);
            end
         end
         RCNC_RECV: begin
            if (i_stream_end && r.opcfg[OP_NOISE]) begin
               n.mode = RCNC_CHECK;
            end else if (poll_rise) begin
               n.mode      = RCNC_SLEEP;
               n.sleep_cnt = sleep_load(r.opcfg);
            end
         end
         default: begin
            n.mode      = RCNC_SLEEP;
            n.sleep_cnt = sleep_load(r.opcfg);
         end
      endcase

      if (off_cmd) begin
         if (!i_polling_sel) begin
            n.mode = RCNC_CHECK;
         end else begin
            n.mode      = RCNC_SLEEP;
            n.sleep_cnt = sleep_load(r.opcfg);
         end
      end

      // Marker square wave
      if (r.marker) begin
         if (r.mark_cnt == 16'h0000) begin
            n.mark_cnt   = 16'(MARK_HALF - 1);
            n.mark_phase = !r.mark_phase;
         end else begin
            n.mark_cnt = r.mark_cnt - 16'h0001;
         end
      end

      // Data line, open drain
      if (n.marker) begin
         n.data_out = n.mark_phase;
      end else if (r.mode == RCNC_RECV && n.mode == RCNC_RECV) begin
         n.data_out = i_demod_data;
      end else begin
         n.data_out = 1'b1;
      end
      n.data_oe = !n.data_out && !n.framing;
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         r            <= '0;
         r.mode       <= RCNC_CHECK;
         r.opcfg      <= OPCFG_RESET;
         r.limits     <= LIMITS_RESET;
         r.poll_prev  <= 1'b1;
         r.marker     <= 1'b1;
         r.mark_phase <= 1'b1;
         r.data_out   <= 1'b1;
         r.scale      <= 4'h8;
         r.check_n    <= 4'h3;
      end else begin
         r <= n;
      end
   end

   assign o_data_out            = r.data_out;
   assign o_data_oe             = r.data_oe;
   assign o_mode                = r.mode;
   assign o_baud_band_select    = r.opcfg[OP_BAUD_HI:OP_BAUD_LO];
   assign o_limit_scale_factor  = r.scale;
   assign o_edge_check_count    = r.check_n;
   assign o_modulation_select   = r.opcfg[OP_MOD];
   assign o_sleep_value         = r.opcfg[OP_SLEEP_HI:OP_SLEEP_LO];
   assign o_sleep_extend_select = r.opcfg[OP_EXT];
   assign o_noise_suppress_en   = r.opcfg[OP_NOISE];
   assign o_lim_min             = r.limits[LIM_MIN_HI:LIM_MIN_LO];
   assign o_lim_max             = r.limits[LIM_MAX_HI:LIM_MAX_LO];
   assign o_power_loss_marker   = r.marker;

   // Checks
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_suppress_enter;
      r.mode == RCNC_RECV && i_stream_end && r.opcfg[OP_NOISE] && !off_cmd;
   endsequence

   sequence s_held_high;
      r.mode == RCNC_CHECK ##1 (r.data_out || r.marker);
   endsequence

   chk_noise_pass: assert property (
      (r.mode == RCNC_RECV && i_stream_end && !r.opcfg[OP_NOISE] && !off_cmd && !poll_rise)
      |=> r.mode == RCNC_RECV)
      else $error("noise pass left receiving mode");

   chk_pin_low_hold: assert property (
      (r.mode == RCNC_RECV && !i_polling_sel && !off_cmd
       && !(i_stream_end && r.opcfg[OP_NOISE])) |=> r.mode == RCNC_RECV)
      else $error("receiving mode lost with select low");

   chk_off_startup: assert property (
      (off_cmd && !i_polling_sel) |=> r.mode == RCNC_CHECK)
      else $error("off with select low did not start bit check");

   chk_skip_sleep: assert property (
      (r.mode == RCNC_CHECK && !i_polling_sel && !off_cmd) |=> r.mode != RCNC_SLEEP)
      else $error("sleep entered with select low");

   chk_check_ok: assert property (
      (r.mode == RCNC_CHECK && i_check_ok && !off_cmd) |=> r.mode == RCNC_RECV)
      else $error("bit check success ignored");

   chk_off_polling: assert property (
      (off_cmd && i_polling_sel) |=> r.mode == RCNC_SLEEP)
      else $error("off did not enter polling");

   chk_stop_discard: assert property (
      (frame_done && fr[FR_STOP]) |=> $stable(r.opcfg) && $stable(r.limits))
      else $error("frame with stop bit set was written");

   chk_op_write: assert property (
      (frame_done && !fr[FR_OFF] && fr[FR_SEL] && !fr[FR_STOP])
      |=> r.opcfg == $past(fr_cfg) && $stable(r.limits))
      else $error("operating register write wrong");

   chk_lim_write: assert property (
      (frame_done && !fr[FR_OFF] && !fr[FR_SEL] && !fr[FR_STOP])
      |=> r.limits == $past(fr_cfg) && $stable(r.opcfg))
      else $error("limits register write wrong");

   chk_scale_map: assert property (
      r.scale == (4'h8 >> r.opcfg[OP_BAUD_HI:OP_BAUD_LO]))
      else $error("limit scale does not follow baud band");

   chk_count_map: assert property (
      r.check_n == 4'({2'b00, r.opcfg[OP_CHK_HI:OP_CHK_LO]} * 4'h3))
      else $error("check count does not follow its field");

   chk_frame_release: assert property (
      r.framing |-> !r.data_oe)
      else $error("data line driven during a frame");

   chk_suppress_high: assert property (
      s_suppress_enter |=> s_held_high)
      else $error("suppression did not hold data high");

   chk_frame_length: assert property (
      frame_done |-> r.nbits == FRAME_LAST && r.framing)
      else $error("frame decoded before fifteen bits");

   chk_marker_clear: assert property (
      i_frame_start |=> !r.marker ##1 !r.marker)
      else $error("marker not cancelled by start pulse");

endmodule // rcnc_receiver_config

`default_nettype wire

// ==== sim/rcnc_host_model.sv ====
`default_nettype none
module rcnc_host_model (
   input  wire logic i_core_clk,
   input  wire logic i_data_oe,
   output var  logic o_frame_start,
   output var  logic o_slot,
   output var  logic o_data_in,
   output var  logic o_polling_sel
);
   timeunit 1ns;
   timeprecision 1ns;
   logic drive_bit;
   logic framing;
   // Pull-up wins unless the device pulls low
   assign o_data_in = framing ? drive_bit : !i_data_oe;
   initial begin
      o_frame_start = 1'b0;
      o_slot        = 1'b0;
      o_polling_sel = 1'b1;
      drive_bit     = 1'b1;
      framing       = 1'b0;
   end
   // Frame bit 1 sits in f[14]
   task send(input logic [14:0] f);
      int k;
      @(negedge i_core_clk);
      o_frame_start = 1'b1;
      @(negedge i_core_clk);
      o_frame_start = 1'b0;
      framing = 1'b1;
      for (k = 14; k >= 0; k--) begin
         o_slot    = 1'b1;
         drive_bit = f[k];
         @(negedge i_core_clk);
      end
      o_slot  = 1'b0;
      framing = 1'b0;
   endtask
   task set_sel(input logic v);
      @(negedge i_core_clk);
      o_polling_sel = v;
   endtask
endmodule // rcnc_host_model
`default_nettype wire

// ==== sim/test_rcnc_receiver_config.sv ====
`default_nettype none
module test_rcnc_receiver_config;
   timeunit 1ns;
   timeprecision 1ns;
   import rcnc_pkg::*;
   logic clk, rst, demod, s_end, c_ok, c_fail, due;
   logic fst, slot, din, psel, dout, doe, mdl, ext, nse, mark;
   rcnc_mode_t mode;
   logic [1:0] band;
   logic [3:0] scl, cnt;
   logic [4:0] slp;
   logic [5:0] lmin, lmax;
   logic [11:0] op_m, lim_m;
   logic [31:0] q[$];
   int num_errors, comparisons, i, n;
   rcnc_receiver_config #(.SLEEP_UNIT(4), .MARK_HALF(4)) rcnc_receiver_config_inst (
      .i_core_clk(clk), .i_rst(rst), .i_data_in(din), .o_data_out(dout),
      .o_data_oe(doe), .i_frame_start(fst), .i_slot(slot), .i_polling_sel(psel),
      .i_demod_data(demod), .i_stream_end(s_end), .i_check_ok(c_ok),
      .i_check_fail(c_fail), .o_mode(mode), .o_baud_band_select(band),
      .o_limit_scale_factor(scl), .o_edge_check_count(cnt), .o_modulation_select(mdl),
      .o_sleep_value(slp), .o_sleep_extend_select(ext), .o_noise_suppress_en(nse),
      .o_lim_min(lmin), .o_lim_max(lmax), .o_power_loss_marker(mark));
   rcnc_host_model rcnc_host_model_inst (.i_core_clk(clk), .i_data_oe(doe),
      .o_frame_start(fst), .o_slot(slot), .o_data_in(din), .o_polling_sel(psel));
   initial begin
      clk = 1'b0;
      forever #25 clk = !clk;
   end
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task close_out;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Scale 8>>band, count 3*field, then raw fields
   task note(input logic [1:0] m);
      q.push_back({m, op_m[11:10], 4'h8 >> op_m[11:10], {2'b00, op_m[9:8]} * 4'h3,
                   op_m[7:0], lim_m});
      due <= 1'b1;
      @(negedge clk);
      @(negedge clk);
   endtask
   always @(negedge clk) begin
      if (due) begin
         due = 1'b0;
         check("outputs", {mode, band, scl, cnt, mdl, slp, ext, nse, lmin, lmax},
               q.pop_front());
      end
   end
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   task wr(input logic off, sel, input logic [11:0] v, input logic stop);
      rcnc_host_model_inst.send({off, sel, v, stop});
      if (!off && !stop && sel) op_m = v;
      if (!off && !stop && !sel) lim_m = v;
   endtask
   initial begin
      {rst, demod, s_end, c_ok, c_fail, due} = 6'b100000;
      op_m  = 12'h119;
      lim_m = 12'h569;
      void'($urandom(89));
      repeat (20) @(negedge clk);
      rst = 1'b0;
      check("marker", 32'(mark), 32'h1);
      note(2'b01);
      check("marker_oe", 32'(doe), 32'(!dout));
      n = int'(dout);
      repeat (2) @(negedge clk);
      check("marker_hold", 32'(dout), 32'(n));
      repeat (2) @(negedge clk);
      check("marker_flip", 32'(dout), 32'(!n[0]));
      pulse(c_ok);
      note(2'b11);
      wr(1'b0, 1'b0, 12'($urandom), 1'b0);
      note(2'b11);
      check("marker", 32'(mark), 32'h0);
      for (i = 0; i < 4; i++) begin
         wr(1'b0, 1'b1, {i[1:0], i[1:0], 8'($urandom)}, 1'b0);
         note(2'b11);
      end
      wr(1'b0, 1'b1, 12'($urandom), 1'b1);
      note(2'b11);
      wr(1'b0, 1'b1, 12'h108, 1'b0);
      pulse(s_end);
      note(2'b11);
      for (i = 0; i < 2; i++) begin
         demod = i[0];
         repeat (2) @(negedge clk);
         check("data", 32'({dout, doe}), 32'({i[0], !i[0]}));
      end
      rcnc_host_model_inst.set_sel(1'b0);
      repeat (8) @(negedge clk);
      note(2'b11);
      wr(1'b1, 1'b1, 12'($urandom), 1'b0);
      repeat (10) @(negedge clk);
      note(2'b01);
      pulse(c_ok);
      note(2'b11);
      wr(1'b0, 1'b1, 12'h109, 1'b0);
      pulse(s_end);
      note(2'b01);
      check("data", 32'({dout, doe}), 32'h2);
      pulse(c_fail);
      note(2'b01);
      pulse(c_ok);
      note(2'b11);
      rcnc_host_model_inst.set_sel(1'b1);
      note(2'b00);
      for (n = 0; n < 40 && mode !== RCNC_CHECK; n++) @(negedge clk);
      if (n == 40) begin
         num_errors++;
         close_out();
      end
      check("sleep", 32'(n + 1), 32'(2 * 4));
      pulse(c_ok);
      wr(1'b1, 1'b0, 12'($urandom), 1'b1);
      note(2'b00);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      op_m  = 12'h119;
      lim_m = 12'h569;
      check("marker", 32'(mark), 32'h1);
      note(2'b01);
      close_out();
   end
endmodule // test_rcnc_receiver_config
`default_nettype wire
